/* File: tcm_far.sv */
// Far-side model: tagged input bytes and a slow output sink
`timescale 1ns/1ps
module tcm_far (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [5:0] out_channel_i,
    input  wire logic       out_valid_i,
    input  wire logic [7:0] out_byte_i,
    input  wire logic       stall_i,
    output logic            out_ready_o,
    output logic [15:0]     stream_o
);
    typedef struct packed {
        logic [3:0] frm;
        logic [5:0] ch;
        logic [8:0] idx;
        logic       ph;
    } tcm_far_t;
    tcm_far_t   st_reg;
    logic [7:0] got_b [32];
    logic [3:0] got_f [32];
    // Frame tag in every byte, so a delay shows as a tag difference
    assign stream_o    = {4'h8, st_reg.frm, 4'h0, st_reg.frm};
    // Ready every other cycle at most: no kinder than a real sink
    assign out_ready_o = !stall_i && st_reg.ph;
    // Tag moves after the last channel is pushed, before channel 0 samples
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg.ph <= !st_reg.ph;
            st_reg.ch <= out_channel_i;
            if (out_channel_i == 6'h1F && st_reg.ch != 6'h1F) begin
                st_reg.frm <= st_reg.frm + 4'h1;
            end
            if (out_valid_i && out_ready_o) begin
                got_b[st_reg.idx[4:0]] <= out_byte_i;
                got_f[st_reg.idx[4:0]] <= st_reg.idx[8:5];
                st_reg.idx             <= st_reg.idx + 9'h001;
            end
        end
    end
endmodule

/* File: tcm_fifo.sv */
// Small synchronous FIFO for switched output bytes
`timescale 1ns/1ps
module tcm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
        logic [WIDTH-1:0]            dout;
        logic                        dvalid;
    } tcm_fifo_st_t;
    tcm_fifo_st_t st_reg;
    tcm_fifo_st_t st_next;
    logic push;
    logic pop;

    // Output stage is a register so the consumer sees flop outputs
    always_comb begin
        st_next = st_reg;
        push = in_valid_i && (st_reg.count != (AW+1)'(DEPTH));
        pop  = (st_reg.count != '0) && (!st_reg.dvalid || out_ready_i);
        if (st_reg.dvalid && out_ready_i) begin
            st_next.dvalid = 1'b0;
        end
        if (pop) begin
            st_next.dout   = st_reg.mem[st_reg.rptr];
            st_next.dvalid = 1'b1;
            st_next.rptr   = st_reg.rptr + 1'b1;
        end
        if (push) begin
            st_next.mem[st_reg.wptr] = in_data_i;
            st_next.wptr = st_reg.wptr + 1'b1;
        end
        st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
        if (!rst_n_i) begin
            st_next = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        st_reg <= st_next;
    end

    assign in_ready_o  = st_reg.count != (AW+1)'(DEPTH);
    assign out_valid_o = st_reg.dvalid;
    assign out_data_o  = st_reg.dout;
endmodule

/* File: tcm_pkg.sv */
// Shared constants for the timeslot connection memory block
package tcm_pkg;
    // Host port addresses
    localparam logic [7:0] ADDR_MAIN_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_MODE_SEL   = 8'h01;
    localparam logic [7:0] ADDR_MAIN_RD    = 8'h02;
    localparam logic [1:0] PAGE_LOW        = 2'h1;
    localparam logic [1:0] PAGE_HIGH       = 2'h2;
    // Main control register fields
    localparam int FILL_EN_BIT   = 3;
    localparam int VAR_EN_BIT    = 4;
    // Mode selection register fields
    localparam int FILL_START_BIT = 0;
    localparam int PAT_LSB        = 1;
    localparam int PAT_MSB        = 3;
    // Low connection word fields
    localparam int MODE_BIT      = 0;
    localparam int SRC_CH_LSB    = 1;
    localparam int SRC_CH_MSB    = 8;
    localparam int SRC_ST_LSB    = 9;
    localparam int SRC_ST_MSB    = 13;
    localparam int MSG_LSB       = 3;
    localparam int MSG_MSB       = 10;
    localparam int DELAY_BIT     = 14;
    localparam int LAW_EN_BIT    = 15;
    // High connection word fields
    localparam int HI_W          = 5;
    localparam int HI_IN_LAW     = 1;
    localparam int HI_OUT_LAW    = 2;
    localparam int HI_VOICE      = 0;
    // Reset values and fill data
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] MODE_RST  = 16'h0000;
    localparam logic [7:0]  INVALID_BYTE = 8'hFF;
    localparam logic [7:0]  LAW_XOR   = 8'h55;
    // Timing: frame length and channel window of variable delay
    localparam int FRAME_NS      = 125000;
    localparam int CLK_NS        = 20;
    localparam int FRAME_CYC     = FRAME_NS / CLK_NS;
    localparam int VAR_WINDOW    = 7;
    localparam int NUM_BANKS     = 3;
endpackage

/* File: tcm_switch.sv */
// Connection memory, throughput delay control and block fill engine
`timescale 1ns/1ps
module tcm_switch #(
    parameter int NUM_CH      = 32,
    parameter int NUM_ST      = 2,
    parameter int FRAME_CYCLES = tcm_pkg::FRAME_CYC,
    parameter int FIFO_DEPTH  = 16
) (
    input  wire logic                core_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                host_cs_i,
    input  wire logic                host_wr_i,
    input  wire logic [7:0]          host_addr_i,
    input  wire logic [15:0]         host_wdata_i,
    output logic      [15:0]         host_rdata_o,
    output logic                     host_ack_o,
    input  wire logic [NUM_ST*8-1:0] serial_input_stream_i,
    output logic      [7:0]          serial_output_stream_o,
    output logic                     out_valid_o,
    input  wire logic                out_ready_i,
    output logic      [5:0]          out_channel_o,
    output logic                     fill_busy_o
);
    localparam int CW = $clog2(NUM_CH);
    localparam int SW = (NUM_ST > 1) ? $clog2(NUM_ST) : 1;
    localparam int CH_CYC = FRAME_CYCLES / NUM_CH;
    // Fill must cover at least two whole frames
    localparam int FILL_CYC = 2 * FRAME_CYCLES;

    typedef enum logic [2:0] {
        FS_IDLE = 3'b001,
        FS_FILL = 3'b010,
        FS_WAIT = 3'b100
    } tcm_fill_t;

    typedef struct packed {
        logic [NUM_CH-1:0][15:0]                   cm_low;
        logic [NUM_CH-1:0][tcm_pkg::HI_W-1:0]      cm_high;
        logic [tcm_pkg::NUM_BANKS-1:0][NUM_ST-1:0][NUM_CH-1:0][7:0] bank;
        logic [15:0]    ctrl;
        logic [15:0]    mode;
        logic [15:0]    rdata;
        logic           ack;
        logic [15:0]    tick;
        logic [CW-1:0]  chan;
        logic [1:0]     cur_bank;
        logic [7:0]     out_byte;
        logic           out_push;
        logic [5:0]     out_chan;
        tcm_fill_t      fstate;
        logic [CW-1:0]  faddr;
        logic [31:0]    fcnt;
    } tcm_st_t;

    tcm_st_t st_reg;
    tcm_st_t st_next;

    logic       fifo_ready;
    logic [15:0] lw;
    logic [tcm_pkg::HI_W-1:0] hw;
    logic [CW-1:0] src_ch;
    logic [SW-1:0] src_st;
    logic [1:0]    prev_bank;
    logic [1:0]    old_bank;
    logic [1:0]    rd_bank;
    logic [7:0]    byte_v;
    logic          var_sel;
    logic          fill_run;
    logic          tick_now;
    logic [1:0]    page;
    logic [CW-1:0] wch;
    integer        diff;

    // Host decode, timing, switching and fill engine in one pass
    always_comb begin
        st_next   = st_reg;
        page      = host_addr_i[7:6];
        wch       = host_addr_i[CW-1:0];
        fill_run  = (st_reg.fstate != FS_IDLE);
        tick_now  = (st_reg.tick == 16'(CH_CYC - 1)) && fifo_ready;
        lw        = st_reg.cm_low[st_reg.chan];
        hw        = st_reg.cm_high[st_reg.chan];
        src_ch    = lw[tcm_pkg::SRC_CH_LSB +: CW];
        src_st    = lw[tcm_pkg::SRC_ST_LSB +: SW];
        prev_bank = (st_reg.cur_bank == 2'h0) ? 2'h2 : st_reg.cur_bank - 2'h1;
        old_bank  = (prev_bank == 2'h0) ? 2'h2 : prev_bank - 2'h1;
        diff      = int'(st_reg.chan) - int'(src_ch);
        var_sel   = lw[tcm_pkg::DELAY_BIT];
        rd_bank   = old_bank;
        byte_v    = '0;

        // Single-cycle host access; ack and data one edge later
        st_next.ack   = host_cs_i;
        st_next.rdata = '0;
        if (host_cs_i && !host_wr_i) begin
            if (host_addr_i == tcm_pkg::ADDR_MAIN_CTRL) begin
                st_next.rdata = st_reg.ctrl;
            end else if (host_addr_i == tcm_pkg::ADDR_MODE_SEL) begin
                st_next.rdata = st_reg.mode;
            end else if (page == tcm_pkg::PAGE_LOW && int'(wch) < NUM_CH) begin
                st_next.rdata = st_reg.cm_low[wch];
            end else if (page == tcm_pkg::PAGE_HIGH && int'(wch) < NUM_CH) begin
                st_next.rdata = {11'h000, st_reg.cm_high[wch]};
            end
        end
        if (host_cs_i && host_wr_i) begin
            if (host_addr_i == tcm_pkg::ADDR_MAIN_CTRL) begin
                st_next.ctrl = host_wdata_i;
            end else if (host_addr_i == tcm_pkg::ADDR_MODE_SEL) begin
                st_next.mode = host_wdata_i;
            end else if (page == tcm_pkg::PAGE_LOW && !fill_run) begin
                st_next.cm_low[wch] = host_wdata_i;
            end else if (page == tcm_pkg::PAGE_HIGH && !fill_run) begin
                st_next.cm_high[wch] = host_wdata_i[tcm_pkg::HI_W-1:0];
            end
        end

        // Channel timing; holds while the output FIFO is full
        st_next.out_push = 1'b0;
        if (fifo_ready) begin
            st_next.tick = tick_now ? 16'h0000 : st_reg.tick + 16'h0001;
        end
        if (tick_now) begin
            for (int s = 0; s < NUM_ST; s++) begin
                st_next.bank[st_reg.cur_bank][s][st_reg.chan] =
                    serial_input_stream_i[s*8 +: 8];
            end
            // Variable delay: same frame only if source is well ahead
            if (var_sel && diff > tcm_pkg::VAR_WINDOW) begin
                rd_bank = st_reg.cur_bank;
            end else if (var_sel) begin
                rd_bank = prev_bank;
            end else begin
                rd_bank = old_bank;
            end
            byte_v = st_reg.bank[rd_bank][src_st][src_ch];
            if (var_sel && !st_reg.ctrl[tcm_pkg::VAR_EN_BIT]) begin
                byte_v = tcm_pkg::INVALID_BYTE;
            end
            if (lw[tcm_pkg::MODE_BIT]) begin
                byte_v = lw[tcm_pkg::MSG_MSB:tcm_pkg::MSG_LSB];
            end
            // Translation stage models only the even-bit inversion
            if (lw[tcm_pkg::LAW_EN_BIT] && hw[tcm_pkg::HI_VOICE] &&
                (hw[tcm_pkg::HI_IN_LAW] != hw[tcm_pkg::HI_OUT_LAW])) begin
                byte_v = byte_v ^ tcm_pkg::LAW_XOR;
            end
            st_next.out_byte = byte_v;
            st_next.out_push = 1'b1;
            st_next.out_chan = 6'(st_reg.chan);
            if (int'(st_reg.chan) == NUM_CH - 1) begin
                st_next.chan     = '0;
                st_next.cur_bank = (st_reg.cur_bank == 2'h2) ? 2'h0 :
                                   st_reg.cur_bank + 2'h1;
            end else begin
                st_next.chan = st_reg.chan + 1'b1;
            end
        end

        // Block fill engine
        unique case (st_reg.fstate)
            FS_IDLE: begin
                if (st_reg.ctrl[tcm_pkg::FILL_EN_BIT] &&
                    st_reg.mode[tcm_pkg::FILL_START_BIT]) begin
                    st_next.fstate = FS_FILL;
                    st_next.faddr  = '0;
                    st_next.fcnt   = '0;
                end
            end
            FS_FILL: begin
                st_next.cm_low[st_reg.faddr] =
                    {13'h0000, st_reg.mode[tcm_pkg::PAT_MSB:tcm_pkg::PAT_LSB]};
                st_next.cm_high[st_reg.faddr] = '0;
                st_next.fcnt  = st_reg.fcnt + 32'h1;
                st_next.faddr = st_reg.faddr + 1'b1;
                if (int'(st_reg.faddr) == NUM_CH - 1) begin
                    st_next.fstate = FS_WAIT;
                end
            end
            FS_WAIT: begin
                st_next.fcnt = st_reg.fcnt + 32'h1;
                if (st_reg.fcnt >= 32'(FILL_CYC - 1)) begin
                    st_next.fstate = FS_IDLE;
                    st_next.mode[tcm_pkg::FILL_START_BIT] = 1'b0;
                end
            end
        endcase
        // Abort when host drops start or enable; enable stays host-owned
        if (fill_run && (!st_reg.ctrl[tcm_pkg::FILL_EN_BIT] ||
                         !st_reg.mode[tcm_pkg::FILL_START_BIT])) begin
            st_next.fstate = FS_IDLE;
        end

        if (!rst_n_i) begin
            st_next        = '0;
            st_next.ctrl   = tcm_pkg::CTRL_RST;
            st_next.mode   = tcm_pkg::MODE_RST;
            st_next.fstate = FS_IDLE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        st_reg <= st_next;
    end

    // Output bytes queue here; a stalled reader freezes channel timing
    tcm_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (st_reg.out_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (st_reg.out_byte),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (serial_output_stream_o)
    );

    assign host_rdata_o  = st_reg.rdata;
    assign host_ack_o    = st_reg.ack;
    assign out_channel_o = st_reg.out_chan;
    assign fill_busy_o   = (st_reg.fstate != FS_IDLE);
endmodule

/* File: tcm_switch_sva.sv */
// Checker of host port timing, fill engine and output hold
`timescale 1ns/1ps
module tcm_switch_sva #(
    parameter int FRAME_CYCLES = tcm_pkg::FRAME_CYC
) (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic        host_cs_i,
    input wire logic        host_wr_i,
    input wire logic [7:0]  host_addr_i,
    input wire logic [15:0] host_wdata_i,
    input wire logic [15:0] host_rdata_o,
    input wire logic        host_ack_o,
    input wire logic [7:0]  serial_output_stream_o,
    input wire logic        out_valid_o,
    input wire logic        out_ready_i,
    input wire logic        fill_busy_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Counter wide enough for two frames at the full frame length
    typedef struct packed { logic [15:0] cnt; logic abort; } tcm_chk_t;
    tcm_chk_t st_reg;
    tcm_chk_t st_next;
    logic     wr_hit;
    // Busy length; a fill cut short by the host is exempt from the minimum
    assign wr_hit = host_cs_i && host_wr_i && ((host_addr_i == tcm_pkg::ADDR_MAIN_CTRL &&
        !host_wdata_i[tcm_pkg::FILL_EN_BIT]) || (host_addr_i == tcm_pkg::ADDR_MODE_SEL &&
        !host_wdata_i[tcm_pkg::FILL_START_BIT]));
    always_comb begin
        st_next.cnt   = fill_busy_o ? st_reg.cnt + 16'h0001 : 16'h0000;
        st_next.abort = fill_busy_o && (st_reg.abort || wr_hit);
    end
    always_ff @(posedge core_clk_i) begin
        st_reg <= rst_n_i ? st_next : '0;
    end
    // Host clears start or enable while the fill runs
    sequence s_start_clear;
        fill_busy_o && host_cs_i && host_wr_i && host_addr_i == tcm_pkg::ADDR_MODE_SEL
            && !host_wdata_i[tcm_pkg::FILL_START_BIT];
    endsequence
    sequence s_enable_clear;
        fill_busy_o && host_cs_i && host_wr_i && host_addr_i == tcm_pkg::ADDR_MAIN_CTRL
            && !host_wdata_i[tcm_pkg::FILL_EN_BIT];
    endsequence
    a_ack_after_cs: assert property (host_cs_i |=> host_ack_o)
        else $error("ack missing after access");
    a_rdata_idle_zero: assert property (!host_ack_o |-> host_rdata_o == 16'h0000)
        else $error("read data not zero outside ack");
    a_high_rsvd_zero: assert property (host_cs_i && !host_wr_i && host_addr_i[7:6] == 2'h2
        |=> host_rdata_o[15:5] == 11'h000) else $error("high word reserved bits not zero");
    a_abort_by_start: assert property (s_start_clear |-> ##[1:3] !fill_busy_o)
        else $error("fill kept running after start cleared");
    a_abort_by_enable: assert property (s_enable_clear |-> ##[1:3] !fill_busy_o)
        else $error("fill kept running after enable cleared");
    a_fill_min_len: assert property ($fell(fill_busy_o) && !st_reg.abort
        |-> st_reg.cnt >= 16'(2 * FRAME_CYCLES - 2)) else $error("fill ended too early");
    a_fill_max_len: assert property (st_reg.cnt <= 16'(2 * FRAME_CYCLES + 8))
        else $error("fill never finished");
    a_valid_holds: assert property (out_valid_o && !out_ready_i
        |=> out_valid_o && $stable(serial_output_stream_o)) else $error("output byte dropped");
endmodule

bind tcm_switch tcm_switch_sva #(.FRAME_CYCLES(FRAME_CYCLES)) u_tcm_switch_sva (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .host_cs_i(host_cs_i), .host_wr_i(host_wr_i),
    .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .host_ack_o(host_ack_o), .serial_output_stream_o(serial_output_stream_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .fill_busy_o(fill_busy_o));

/* File: tcm_switch_tb.sv */
// Bench for the connection memory, delay paths and block fill
`timescale 1ns/1ps
module tcm_switch_tb;
    localparam int FC = 320;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        cs    = 1'b0;
    logic        wr    = 1'b0;
    logic [7:0]  addr  = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        stall = 1'b0;
    logic [15:0] rdata;
    logic [15:0] sin;
    logic [7:0]  sout;
    logic [5:0]  och;
    logic        ack;
    logic        ov;
    logic        ordy;
    logic        busy;
    int          fail_count  = 0;
    int          check_count = 0;
    always #10 clk = !clk;
    tcm_switch #(.NUM_CH(32), .NUM_ST(2), .FRAME_CYCLES(FC), .FIFO_DEPTH(16)) u_tcm_switch (
        .core_clk_i(clk), .rst_n_i(rst_n), .host_cs_i(cs), .host_wr_i(wr), .host_addr_i(addr),
        .host_wdata_i(wdata), .host_rdata_o(rdata), .host_ack_o(ack),
        .serial_input_stream_i(sin), .serial_output_stream_o(sout), .out_valid_o(ov),
        .out_ready_i(ordy), .out_channel_o(och), .fill_busy_o(busy));
    tcm_far u_tcm_far (.core_clk_i(clk), .rst_n_i(rst_n), .out_channel_i(och),
        .out_valid_i(ov), .out_byte_i(sout), .stall_i(stall), .out_ready_o(ordy), .stream_o(sin));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One access; answer taken just after the edge that accepts it
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        @(posedge clk);
        cs <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        cs <= 1'b0;
        #1;
        q = rdata;
        chk("ack", 16'h0001, {15'h0000, ack});
    endtask
    task automatic wrt(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        acc(1'b0, a, 16'h0000, q);
        chk(nm, e, q);
    endtask
    // Output byte of channel n must carry the tag k frames older
    task automatic chkb(input string nm, input int n, input logic s, input logic [3:0] k);
        chk(nm, {8'h00, s, 3'h0, 4'(u_tcm_far.got_f[n] - k)}, {8'h00, u_tcm_far.got_b[n]});
    endtask
    task automatic test_regs();
        rdchk("ctrl reset", tcm_pkg::ADDR_MAIN_CTRL, tcm_pkg::CTRL_RST);
        wrt(8'h45, 16'hFFFF);
        rdchk("low word", 8'h45, 16'hFFFF);
        wrt(8'h85, 16'hFFFF);
        rdchk("high word", 8'h85, 16'h001F);
        wrt(8'h3F, 16'h1234);
        rdchk("unmapped", 8'h3F, 16'h0000);
    endtask
    // Constant, variable and message channels, across a full FIFO
    task automatic test_paths();
        wrt(tcm_pkg::ADDR_MAIN_CTRL, 16'h0010);
        wrt(8'h54, 16'h0204);
        wrt(8'h43, 16'h003C);
        wrt(8'h49, 16'h4004);
        wrt(8'h4C, 16'h4204);
        wrt(8'h41, 16'h400A);
        wrt(8'h99, 16'h0003);
        wrt(8'h59, 16'h0529);
        wrt(8'h9A, 16'h0003);
        wrt(8'h5A, 16'h81E1);
        @(posedge clk);
        stall <= 1'b1;
        repeat (400) @(posedge clk);
        stall <= 1'b0;
        #1;
        chk("fifo held", 16'h0001, {15'h0000, ov});
        repeat (6 * FC) @(posedge clk);
        #1;
        chkb("const st1", 20, 1'b1, 4'h2);
        chkb("const wrap", 3, 1'b0, 4'h2);
        chkb("var near", 9, 1'b0, 4'h1);
        chkb("var far", 12, 1'b1, 4'h0);
        chkb("var back", 1, 1'b0, 4'h1);
        chk("msg plain", 16'h00A5, {8'h00, u_tcm_far.got_b[25]});
        chk("msg law", 16'h0069, {8'h00, u_tcm_far.got_b[26]});
    endtask
    task automatic test_fill();
        int n;
        wrt(tcm_pkg::ADDR_MAIN_CTRL, 16'h0008);
        wrt(tcm_pkg::ADDR_MODE_SEL, 16'h000A);
        wrt(tcm_pkg::ADDR_MODE_SEL, 16'h000B);
        // Engine leaves idle one edge after the start bit lands
        @(posedge clk);
        #1;
        chk("fill busy", 16'h0001, {15'h0000, busy});
        wrt(8'h47, 16'hFFFF);
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("fill length", 16'h0001, {15'h0000, n >= 2 * FC - 8});
        rdchk("start clear", tcm_pkg::ADDR_MODE_SEL, 16'h000A);
        rdchk("enable kept", tcm_pkg::ADDR_MAIN_CTRL, 16'h0008);
        rdchk("low fill", 8'h47, 16'h0005);
        rdchk("high fill", 8'h9A, 16'h0000);
        wrt(tcm_pkg::ADDR_MODE_SEL, 16'h000B);
        wrt(tcm_pkg::ADDR_MAIN_CTRL, 16'h0000);
        repeat (4) @(posedge clk);
        #1;
        chk("abort enable", 16'h0000, {15'h0000, busy});
        wrt(tcm_pkg::ADDR_MODE_SEL, 16'h0000);
        wrt(tcm_pkg::ADDR_MAIN_CTRL, 16'h0008);
        wrt(tcm_pkg::ADDR_MODE_SEL, 16'h000B);
        wrt(tcm_pkg::ADDR_MODE_SEL, 16'h000A);
        repeat (4) @(posedge clk);
        #1;
        chk("abort start", 16'h0000, {15'h0000, busy});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_paths();
        test_fill();
        wrap_up();
    end
endmodule
